// ### hw/fct_core_timing.sv
// Contract
// - A machine cycle lasts exactly four oscillator clocks.
// - One address latch strobe pulse in every machine cycle.
// - After reset, timers advance once per twelve oscillator clocks.
// - Software may switch timers to one advance per four clocks.
// - Mostly one machine cycle per instruction byte.
// - Instructions take between one and five machine cycles.
// - External data move takes at least two machine cycles.
// - Direct-to-direct move takes three machine cycles.
// - Instruction results and flag effects match the legacy core.
// - Every standard legacy opcode is decoded and executed.
// - Added special function registers sit at legacy-unused addresses.
// - Memory addressed with the legacy signal sequence.
// - Provide 256 bytes of internal scratchpad memory.
// - Relative branch operand is a signed two's complement byte.
`timescale 1ns/1ns
module fct_core_timing
	import fct_pkg::*;
(
	input wire logic ref_clk, // oscillator clock, 100 MHz
	input wire logic resetn, // asynchronous reset, active low
	output logic ale, // address latch strobe
	output logic psen_n, // program store read strobe, active low
	output logic rd_n, // external data read strobe, active low
	output logic wr_n, // external data write strobe, active low
	output logic [7:0] ad_out, // multiplexed address/data, driven value
	output logic ad_oe_n, // multiplexed bus drive enable, active low
	input wire logic [7:0] ad_in, // multiplexed bus sampled value
	output logic [7:0] addr_hi, // upper address byte
	output fct_instr_t instr, // completed instruction to the executor
	input wire fct_exec_t exec, // executor answer and data move operands
	input wire fct_dir_t dir, // internal register and scratchpad access
	output logic [7:0] sfr_rdata, // added register read data
	output logic [7:0] ram_rdata, // scratchpad read data
	output logic timer_tick, // one-clock timer advance pulse
	output logic mc_strobe // one-clock pulse ending each machine cycle
);

	////////////////////////////////////////////////////////////////////////
	// Machine cycle generator.

	logic [1:0] phase;
	logic mc_end;

	fct_cycle_gen u_cycle (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.phase(phase),
		.mc_end(mc_end)
	);

	assign mc_strobe = mc_end;

	////////////////////////////////////////////////////////////////////////
	// Scratchpad memory.

	fct_scratchpad u_ram (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.we(dir.ram_we),
		.waddr(dir.waddr),
		.wdata(dir.wdata),
		.raddr(dir.raddr),
		.rdata(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Added clock control register and timer prescaler.

	logic tmr_fast;
	logic [3:0] tmr_cnt;
	logic [3:0] tmr_div;

	// Only the added address is writable here; the legacy map stays with
	// the executor, so nothing new can shadow a standard register.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tmr_fast <= FCT_CLK_CTRL_RESET[FCT_TMR_FAST_BIT];
		end else if (dir.sfr_wr && dir.waddr == FCT_CLK_CTRL_ADDR) begin
			tmr_fast <= dir.wdata[FCT_TMR_FAST_BIT];
		end
	end

	always_comb begin
		sfr_rdata = 8'h00;
		if (dir.raddr == FCT_CLK_CTRL_ADDR) begin
			sfr_rdata[FCT_TMR_FAST_BIT] = tmr_fast;
		end
	end

	assign tmr_div = tmr_fast ? FCT_TMR_FAST_DIV : FCT_TMR_SLOW_DIV;

	// The compare is a greater-or-equal so that switching from slow to
	// fast mid-count cannot strand the counter above the new limit.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tmr_cnt <= 4'h0;
			timer_tick <= 1'b0;
		end else if (tmr_cnt >= tmr_div - 4'h1) begin
			tmr_cnt <= 4'h0;
			timer_tick <= 1'b1;
		end else begin
			tmr_cnt <= tmr_cnt + 4'h1;
			timer_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state.

	fct_state_t state;
	fct_state_t next_state;
	logic [15:0] pc;
	logic [15:0] next_pc;
	logic [7:0] opcode;
	logic [7:0] op1;
	logic [7:0] op2;
	logic [1:0] need_bytes;
	logic [1:0] byte_cnt;
	logic [2:0] need_cyc;
	logic [2:0] mc_cnt;
	logic fin;
	logic last_cyc;
	logic [7:0] cur_op;
	logic [7:0] rel_byte;

	// In the opcode cycle the duration is decoded straight off the bus.
	assign cur_op = (state == FCT_ST_FETCH) ? ad_in : opcode;

	always_comb begin
		if (state == FCT_ST_FETCH) begin
			last_cyc = (fct_op_cycles(ad_in) == 3'h1);
		end else begin
			last_cyc = (mc_cnt + 3'h1 == need_cyc);
		end
	end

	// The offset is always the final operand byte.
	assign rel_byte = (need_bytes == 2'h3) ? op2 : op1;

	always_comb begin
		next_pc = pc;
		if (fin && instr.valid && exec.redirect) begin
			if (exec.rel) begin
				next_pc = fct_rel_target(pc, rel_byte);
			end else begin
				next_pc = exec.target;
			end
		end
	end

	always_comb begin
		next_state = FCT_ST_EXEC;
		if (fin) begin
			next_state = FCT_ST_FETCH;
		end else if (byte_cnt < need_bytes) begin
			next_state = FCT_ST_OPND;
		end else if (state == FCT_ST_FETCH && fct_is_xmove(opcode)) begin
			next_state = FCT_ST_XDATA;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= FCT_ST_EXEC;
			mc_cnt <= 3'h0;
			fin <= 1'b1;
		end else if (phase == FCT_PH_RD1) begin
			fin <= last_cyc;
		end else if (mc_end) begin
			state <= next_state;
			mc_cnt <= fin ? 3'h0 : mc_cnt + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte capture at the close of the read window.

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pc <= FCT_PC_RESET;
			opcode <= 8'h00;
			op1 <= 8'h00;
			op2 <= 8'h00;
			need_bytes <= 2'h1;
			need_cyc <= 3'h1;
			byte_cnt <= 2'h1;
		end else if (phase == FCT_PH_RD1) begin
			case (state)
				FCT_ST_FETCH: begin
					opcode <= ad_in;
					need_bytes <= fct_op_bytes(ad_in);
					need_cyc <= fct_op_cycles(ad_in);
					byte_cnt <= 2'h1;
					pc <= pc + 16'h0001;
				end
				FCT_ST_OPND: begin
					if (byte_cnt == 2'h1) begin
						op1 <= ad_in;
					end else begin
						op2 <= ad_in;
					end
					byte_cnt <= byte_cnt + 2'h1;
					pc <= pc + 16'h0001;
				end
				default: begin
					pc <= pc;
				end
			endcase
		end else if (mc_end) begin
			pc <= next_pc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Hand-over of the finished instruction.

	// The executor owns the arithmetic and the flags; the sequencer hands
	// it the untouched opcode and operands so results stay bit-exact.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			instr <= '0;
		end else if (phase == FCT_PH_RD1) begin
			instr.valid <= last_cyc;
			instr.opcode <= cur_op;
			instr.op1 <= (state == FCT_ST_OPND && byte_cnt == 2'h1) ?
				ad_in : op1;
			instr.op2 <= (state == FCT_ST_OPND && byte_cnt == 2'h2) ?
				ad_in : op2;
			instr.pc_next <= (state == FCT_ST_FETCH ||
				state == FCT_ST_OPND) ? pc + 16'h0001 : pc;
			if (state == FCT_ST_XDATA) begin
				instr.xdata <= ad_in;
			end
		end else begin
			instr.valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External bus: address with the strobe, then a two-clock read or write.

	logic nxt_fetch;
	logic xwrite;

	assign nxt_fetch = (next_state == FCT_ST_FETCH) ||
		(next_state == FCT_ST_OPND);
	assign xwrite = opcode[4];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ale <= 1'b0;
			psen_n <= 1'b1;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			ad_out <= 8'h00;
			ad_oe_n <= 1'b1;
			addr_hi <= 8'h00;
		end else begin
			case (phase)
				FCT_PH_END: begin
					ale <= 1'b1;
					if (nxt_fetch) begin
						ad_out <= next_pc[7:0];
						addr_hi <= next_pc[15:8];
						ad_oe_n <= 1'b0;
					end else if (next_state == FCT_ST_XDATA) begin
						ad_out <= exec.xaddr[7:0];
						addr_hi <= exec.xaddr[15:8];
						ad_oe_n <= 1'b0;
					end else begin
						ad_oe_n <= 1'b1;
					end
				end
				FCT_PH_ALE: begin
					ale <= 1'b0;
					if (state == FCT_ST_XDATA && xwrite) begin
						wr_n <= 1'b0;
						ad_out <= exec.xwdata;
						ad_oe_n <= 1'b0;
					end else if (state == FCT_ST_XDATA) begin
						rd_n <= 1'b0;
						ad_oe_n <= 1'b1;
					end else if (state == FCT_ST_EXEC) begin
						ad_oe_n <= 1'b1;
					end else begin
						psen_n <= 1'b0;
						ad_oe_n <= 1'b1;
					end
				end
				FCT_PH_RD0: begin
					ale <= 1'b0;
				end
				default: begin
					psen_n <= 1'b1;
					rd_n <= 1'b1;
					wr_n <= 1'b1;
					ad_oe_n <= 1'b1;
				end
			endcase
		end
	end

endmodule : fct_core_timing

// ### hw/fct_pkg.sv
package fct_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing constants.

	localparam logic [1:0] FCT_PH_ALE = 2'h0;
	localparam logic [1:0] FCT_PH_RD0 = 2'h1;
	localparam logic [1:0] FCT_PH_RD1 = 2'h2;
	localparam logic [1:0] FCT_PH_END = 2'h3;
	localparam logic [1:0] FCT_PH_RESET = 2'h3;
	localparam logic [3:0] FCT_TMR_SLOW_DIV = 4'hC;
	localparam logic [3:0] FCT_TMR_FAST_DIV = 4'h4;

	////////////////////////////////////////////////////////////////////////
	// Addresses, fields and reset values.

	localparam logic [15:0] FCT_PC_RESET = 16'h0000;
	localparam logic [7:0] FCT_CLK_CTRL_ADDR = 8'h8E;
	localparam int FCT_TMR_FAST_BIT = 3;
	localparam logic [7:0] FCT_CLK_CTRL_RESET = 8'h00;
	localparam int FCT_RAM_DEPTH = 256;

	////////////////////////////////////////////////////////////////////////
	// Types.

	typedef enum logic [3:0] {
		FCT_ST_FETCH = 4'b0001,
		FCT_ST_OPND = 4'b0010,
		FCT_ST_XDATA = 4'b0100,
		FCT_ST_EXEC = 4'b1000
	} fct_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [7:0] op2;
		logic [7:0] xdata;
		logic [15:0] pc_next;
	} fct_instr_t;

	typedef struct packed {
		logic redirect;
		logic rel;
		logic [15:0] target;
		logic [15:0] xaddr;
		logic [7:0] xwdata;
	} fct_exec_t;

	typedef struct packed {
		logic sfr_wr;
		logic ram_we;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic [7:0] raddr;
	} fct_dir_t;

	////////////////////////////////////////////////////////////////////////
	// Opcode decode; every one of the 256 codes has a length and a duration.

	function automatic logic [1:0] fct_op_bytes(input logic [7:0] op);
		logic [3:0] row;
		logic [3:0] lo;
		row = op[7:4];
		lo = op[3:0];
		fct_op_bytes = 2'h2;
		if (lo == 4'h1) begin
			fct_op_bytes = 2'h2;
		end else if (lo >= 4'h8) begin
			case (row)
				4'h7, 4'h8, 4'hA, 4'hD: fct_op_bytes = 2'h2;
				4'hB: fct_op_bytes = 2'h3;
				default: fct_op_bytes = 2'h1;
			endcase
		end else if (lo >= 4'h6) begin
			case (row)
				4'h7, 4'h8, 4'hA: fct_op_bytes = 2'h2;
				4'hB: fct_op_bytes = 2'h3;
				default: fct_op_bytes = 2'h1;
			endcase
		end else if (lo == 4'h5) begin
			case (row)
				4'h7, 4'h8, 4'hB, 4'hD: fct_op_bytes = 2'h3;
				4'hA: fct_op_bytes = 2'h1;
				default: fct_op_bytes = 2'h2;
			endcase
		end else if (lo == 4'h4) begin
			case (row)
				4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: fct_op_bytes = 2'h2;
				4'hB: fct_op_bytes = 2'h3;
				default: fct_op_bytes = 2'h1;
			endcase
		end else if (lo == 4'h3) begin
			case (row)
				4'h4, 4'h5, 4'h6: fct_op_bytes = 2'h3;
				default: fct_op_bytes = 2'h1;
			endcase
		end else if (lo == 4'h2) begin
			case (row)
				4'h0, 4'h1: fct_op_bytes = 2'h3;
				4'h2, 4'h3, 4'hE, 4'hF: fct_op_bytes = 2'h1;
				default: fct_op_bytes = 2'h2;
			endcase
		end else begin
			case (row)
				4'h0, 4'hE, 4'hF: fct_op_bytes = 2'h1;
				4'h1, 4'h2, 4'h3, 4'h9: fct_op_bytes = 2'h3;
				default: fct_op_bytes = 2'h2;
			endcase
		end
	endfunction : fct_op_bytes

	function automatic logic fct_is_xmove(input logic [7:0] op);
		fct_is_xmove = (op[7:5] == 3'h7) &&
			(op[3:0] == 4'h0 || op[3:0] == 4'h2 || op[3:0] == 4'h3);
	endfunction : fct_is_xmove

	function automatic logic [2:0] fct_op_cycles(input logic [7:0] op);
		fct_op_cycles = {1'b0, fct_op_bytes(op)};
		if (op[3:0] == 4'h1) begin
			fct_op_cycles = 3'h3;
		end else if (fct_is_xmove(op)) begin
			fct_op_cycles = 3'h2;
		end else if (op == 8'h84 || op == 8'hA4) begin
			fct_op_cycles = 3'h5;
		end else if ((op[7:4] == 4'hB && op[3:0] >= 4'h4) || op == 8'hD5) begin
			fct_op_cycles = 3'h4;
		end else begin
			case (op)
				8'h10, 8'h20, 8'h30, 8'h02, 8'h12, 8'h22, 8'h32:
					fct_op_cycles = 3'h4;
				8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h73, 8'h83, 8'h93, 8'hA3:
					fct_op_cycles = 3'h3;
				default: begin
					if (op[7:4] == 4'hD && op[3:0] >= 4'h8) begin
						fct_op_cycles = 3'h3;
					end
				end
			endcase
		end
	endfunction : fct_op_cycles

	function automatic logic [15:0] fct_rel_target(input logic [15:0] pc,
		input logic [7:0] rel);
		fct_rel_target = pc + {{8{rel[7]}}, rel};
	endfunction : fct_rel_target

endpackage : fct_pkg

// ### hw/fct_cycle_gen.sv
`timescale 1ns/1ns
module fct_cycle_gen
	import fct_pkg::*;
(
	input wire logic ref_clk, // oscillator clock
	input wire logic resetn, // asynchronous reset, active low
	output logic [1:0] phase, // clock within the machine cycle
	output logic mc_end // last clock of a machine cycle
);

	// Four phases make one machine cycle; reset parks on the last one so
	// the first edge after release opens a fresh cycle.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase <= FCT_PH_RESET;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign mc_end = (phase == FCT_PH_END);

endmodule : fct_cycle_gen

// ### hw/fct_scratchpad.sv
`timescale 1ns/1ns
module fct_scratchpad
	import fct_pkg::*;
(
	input wire logic ref_clk, // oscillator clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic we, // write enable
	input wire logic [7:0] waddr, // write address
	input wire logic [7:0] wdata, // write data
	input wire logic [7:0] raddr, // read address
	output logic [7:0] rdata // registered read data
);

	logic [7:0] mem [FCT_RAM_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule : fct_scratchpad

// ### tb/fct_core_timing_sva.sv
`timescale 1ns/1ns
module fct_core_timing_chk
	import fct_pkg::*;
(
	input wire logic ref_clk, // oscillator clock
	input wire logic resetn, // async reset, active low
	input wire logic ale, // address latch strobe
	input wire logic psen_n, // program read strobe
	input wire logic rd_n, // data read strobe
	input wire logic wr_n, // data write strobe
	input wire logic [7:0] ad_out, // bus value
	input wire logic ad_oe_n, // bus drive enable
	input wire fct_instr_t instr, // instruction hand-off
	input wire fct_exec_t exec, // executor answer
	input wire fct_dir_t dir, // register access
	input wire logic [7:0] sfr_rdata, // register read data
	input wire logic timer_tick, // timer pulse
	input wire logic mc_strobe // cycle end pulse
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic fast;
	logic chg;
	logic seen;
	logic [4:0] gap;
	logic ctl_wr;

	assign ctl_wr = dir.sfr_wr && dir.waddr == FCT_CLK_CTRL_ADDR;

	// A rate change restarts nothing, so the period that spans it is skipped.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fast <= 1'b0;
			chg <= 1'b0;
			seen <= 1'b0;
			gap <= 5'h00;
		end else begin
			if (ctl_wr) begin
				fast <= dir.wdata[FCT_TMR_FAST_BIT];
			end
			chg <= ctl_wr ? 1'b1 : (timer_tick ? 1'b0 : chg);
			// The tick clock restarts the count at one, so the gap reads the
			// full period in the clock of the next tick, after reset as well.
			gap <= timer_tick ? 5'h01 : gap + 5'h01;
			seen <= seen | timer_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence cycle_rest;
		!ale [*3] ##1 ale;
	endsequence
	sequence low_two(s);
		!s ##1 s;
	endsequence

	cycle_len_a: assert property (ale |=> cycle_rest)
		else $error("machine cycle length wrong");
	cycle_end_a: assert property (ale |-> ##3 mc_strobe ##1 ale)
		else $error("strobe not once per cycle");
	tick_period_a: assert property (
		timer_tick && seen && !chg |-> gap == (fast ? 5'h04 : 5'h0C))
		else $error("timer period wrong");
	tick_bound_a: assert property (gap <= 5'h0C)
		else $error("timer tick missing");
	psen_win_a: assert property (
		$fell(psen_n) |-> $past(ale) ##1 low_two(psen_n))
		else $error("program strobe window wrong");
	rd_win_a: assert property (
		$fell(rd_n) |-> $past(ale) ##1 low_two(rd_n))
		else $error("read strobe window wrong");
	wr_drive_a: assert property (!wr_n |-> !ad_oe_n)
		else $error("write data not driven");
	valid_phase_a: assert property (instr.valid |-> mc_strobe)
		else $error("hand-off outside cycle end");
	xread_a: assert property (
		instr.valid && instr.opcode == 8'hE0 |-> !$past(rd_n))
		else $error("data read cycle missing");
	rel_target_a: assert property (
		instr.valid && exec.redirect && exec.rel |=>
		ale && ad_out == $past(instr.pc_next[7:0]) + $past(instr.op1))
		else $error("relative target wrong");
	sfr_unused_a: assert property (
		dir.raddr != FCT_CLK_CTRL_ADDR |-> sfr_rdata == 8'h00)
		else $error("register read outside map");
endmodule : fct_core_timing_chk

bind fct_core_timing fct_core_timing_chk chk (.ref_clk(ref_clk), .resetn(resetn),
	.ale(ale), .psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n), .ad_out(ad_out),
	.ad_oe_n(ad_oe_n), .instr(instr), .exec(exec), .dir(dir),
	.sfr_rdata(sfr_rdata), .timer_tick(timer_tick), .mc_strobe(mc_strobe));

// ### tb/fct_mem_model.sv
`timescale 1ns/1ns
module fct_mem_model (
	input wire logic ref_clk, // oscillator clock
	input wire logic slow, // hold read data back one clock
	input wire logic ale, // address latch strobe
	input wire logic psen_n, // program read strobe
	input wire logic rd_n, // data read strobe
	input wire logic wr_n, // data write strobe
	input wire logic [7:0] ad_out, // core bus value
	input wire logic ad_oe_n, // core bus enable
	input wire logic [7:0] addr_hi, // upper address
	output logic [7:0] ad_in // resolved bus level
);
	logic [7:0] prog [0:65535];
	logic [7:0] dmem [0:65535];
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00;
	logic waited = 1'b0;

	always @(posedge ref_clk) begin
		if (ale) begin
			addr <= {addr_hi, ad_out};
		end
		if (!wr_n) begin
			dmem[addr] <= ad_out;
		end
		waited <= !psen_n || !rd_n;
		last <= ad_in;
	end

	// A released bus toggles, so a late sample cannot pass by luck.
	always @* begin
		if (!ad_oe_n) begin
			ad_in = ad_out;
		end else if ((!psen_n || !rd_n) && (waited || !slow)) begin
			ad_in = psen_n ? dmem[addr] : prog[addr];
		end else begin
			ad_in = ~last;
		end
	end
endmodule : fct_mem_model

// ### tb/fct_core_timing_test.sv
`timescale 1ns/1ns
module fct_core_timing_test
	import fct_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic slow = 1'b0;
	logic ale, psen_n, rd_n, wr_n, ad_oe_n, timer_tick, mc_strobe;
	logic [7:0] ad_out, ad_in, addr_hi, sfr_rdata, ram_rdata, op, a, d;
	fct_instr_t instr;
	fct_exec_t exec = '0;
	fct_dir_t dir = '0;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int last_cyc = 0;
	int n_instr = 0;
	logic [15:0] pc = 16'h0000;
	logic [15:0] nxt;
	logic [7:0] seed = 8'h24;
	logic [7:0] img [0:16] = '{8'h74, 8'hFF, 8'h85, 8'hFF, 8'hFF, 8'hA4,
		8'hA3, 8'hE0, 8'hF0, 8'h04, 8'h80, 8'h02, 8'hFF, 8'hFF, 8'h00,
		8'h80, 8'hFE};

	fct_core_timing uut (.ref_clk(ref_clk), .resetn(resetn), .ale(ale),
		.psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n), .ad_out(ad_out),
		.ad_oe_n(ad_oe_n), .ad_in(ad_in), .addr_hi(addr_hi), .instr(instr),
		.exec(exec), .dir(dir), .sfr_rdata(sfr_rdata), .ram_rdata(ram_rdata),
		.timer_tick(timer_tick), .mc_strobe(mc_strobe));
	fct_mem_model mem (.ref_clk(ref_clk), .slow(slow), .ale(ale),
		.psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n), .ad_out(ad_out),
		.ad_oe_n(ad_oe_n), .addr_hi(addr_hi), .ad_in(ad_in));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [15:0] op_len(input logic [7:0] o);
		case (o)
			8'h74, 8'h80: op_len = 16'h0002;
			8'h85: op_len = 16'h0003;
			default: op_len = 16'h0001;
		endcase
	endfunction : op_len
	function automatic logic [15:0] op_cyc(input logic [7:0] o);
		case (o)
			8'h74, 8'hE0, 8'hF0: op_cyc = 16'h0002;
			8'h85, 8'hA3, 8'h80: op_cyc = 16'h0003;
			8'hA4: op_cyc = 16'h0005;
			default: op_cyc = 16'h0001;
		endcase
	endfunction : op_cyc

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (exp !== got) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	task automatic dir_wr(input logic special_function_register, input logic [7:0] wa,
		input logic [7:0] wd);
		@(negedge ref_clk);
		dir.sfr_wr = special_function_register;
		dir.ram_we = !special_function_register;
		dir.waddr = wa;
		dir.wdata = wd;
		@(negedge ref_clk);
		dir.sfr_wr = 1'b0;
		dir.ram_we = 1'b0;
	endtask : dir_wr
	// Measures from a tick seen after any rate change, so no partial period.
	task automatic tick_gap(input logic [15:0] exp);
		int n;
		n = 1;
		while (timer_tick !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
		while (timer_tick !== 1'b1) begin
			n++;
			@(negedge ref_clk);
		end
		check("timer gap", exp, 16'(n));
	endtask : tick_gap

	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (resetn) begin
			cyc++;
		end
		if (cyc > 6000) begin
			err_total++;
			complete_run();
		end
	end

	always @(negedge ref_clk) begin
		exec.redirect = 1'b0;
		exec.rel = 1'b0;
		if (instr.valid === 1'b1) begin
			op = mem.prog[pc];
			check("opcode", {8'h00, op}, {8'h00, instr.opcode});
			if (op_len(op) > 16'h0001) begin
				check("operand", {8'h00, mem.prog[pc + 1]}, {8'h00, instr.op1});
			end
			if (op_len(op) > 16'h0002) begin
				check("operand two", {8'h00, mem.prog[pc + 2]}, {8'h00, instr.op2});
			end
			check("next pc", pc + op_len(op), instr.pc_next);
			check("clocks", 16'h0004 * op_cyc(op), 16'(cyc - last_cyc));
			if (op == 8'hE0) begin
				check("read data", {8'h00, mem.dmem[exec.xaddr]}, {8'h00, instr.xdata});
			end
			nxt = pc + op_len(op);
			if (op == 8'h80) begin
				nxt = nxt + {{8{mem.prog[pc + 1][7]}}, mem.prog[pc + 1]};
			end
			exec.redirect = (op == 8'h80);
			exec.rel = (op == 8'h80);
			pc = nxt;
			last_cyc = cyc;
			n_instr++;
			slow = n_instr[0];
		end
	end

	initial begin
		foreach (img[i]) begin
			seed = lfsr(seed);
			mem.prog[i] = (img[i] == 8'hFF) ? seed : img[i];
		end
		seed = lfsr(seed);
		exec.xaddr = {seed, ~seed};
		exec.xwdata = seed ^ 8'h5A;
		mem.dmem[exec.xaddr] = ~seed;
		repeat (10) @(negedge ref_clk);
		resetn = 1'b1;
		while (n_instr < 14) @(negedge ref_clk);
		check("written data", {8'h00, exec.xwdata}, {8'h00, mem.dmem[exec.xaddr]});
		tick_gap(16'd12);
		dir_wr(1'b1, 8'h8D, 8'hFF);
		dir.raddr = FCT_CLK_CTRL_ADDR;
		@(negedge ref_clk);
		check("clock control", 16'h0000, {8'h00, sfr_rdata});
		dir_wr(1'b1, FCT_CLK_CTRL_ADDR, 8'h08);
		check("clock control", 16'h0008, {8'h00, sfr_rdata});
		tick_gap(16'd4);
		dir_wr(1'b1, FCT_CLK_CTRL_ADDR, 8'h00);
		tick_gap(16'd12);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			a = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : seed);
			d = ~seed;
			dir_wr(1'b0, a, d);
			dir.raddr = a;
			@(negedge ref_clk);
			check("scratchpad", {8'h00, d}, {8'h00, ram_rdata});
		end
		complete_run();
	end
endmodule : fct_core_timing_test
